/* fbep_flash.sv */
// Flash array with per-block erase and per-unit read-only/execute-only protection
// Summary of operation
// - 128 KB of flash made of 1 KB blocks, each erasable alone.
// - Completed block erase leaves the whole block at ones, others untouched.
// - Protection applies per 2 KB unit, covering two adjacent erase blocks.
// - Each unit can be set read-only or execute-only on its own.
// - Erase or program into a read-only unit is refused, contents unchanged.
// - Erase or program into an execute-only unit is refused.
// - Execute-only units return data only to fetches; data and debug reads denied.
// - Reads finish in one clock cycle with no wait states.
`timescale 1ns/1ps
`default_nettype none
module fbep_flash (
   // Clock and synchronous reset
   input wire logic mclk,
   input wire logic rst,
   // Read requests: fetch, data and debug masters
   input wire fbep_pkg::fbep_rd_req_type ifetch_req,
   input wire fbep_pkg::fbep_rd_req_type dread_req,
   input wire fbep_pkg::fbep_rd_req_type dbg_req,
   // Program or erase command, taken while not busy
   input wire fbep_pkg::fbep_mod_req_type mod_req,
   // Protection loads, one unit at a time
   input wire fbep_pkg::fbep_prot_req_type prot_req,
   // Registered read answers, one cycle each
   output fbep_pkg::fbep_rd_rsp_type ifetch_rsp,
   output fbep_pkg::fbep_rd_rsp_type dread_rsp,
   output fbep_pkg::fbep_rd_rsp_type dbg_rsp,
   // Command outcome
   output fbep_pkg::fbep_mod_rsp_type mod_rsp,
   // Current settings per 2 KB unit
   output logic [fbep_pkg::UNIT_CNT-1:0] ronly_map,
   output logic [fbep_pkg::UNIT_CNT-1:0] xonly_map
);
   import fbep_pkg::*;

   // Word address layout, 15 bits wide:
   //    [14:9] protection unit, 64 units of 2 KB
   //    [14:8] erase block, 128 blocks of 1 KB
   //    [7:0] word inside its block, 256 words of 32 bits
   //    one unit is the block pair with equal [14:9], even block first
   // Points a user must know:
   //    commands raised during an erase are dropped, not queued
   //    program and erase on the same edge: erase wins
   //    program only clears bits; erase the block first to set them
   //    a refused command answers done with refused one cycle after it is taken
   //    an erase answers done 257 cycles after it is taken
   //    settings only tighten and stay until the next reset
   //    reads go on during an erase and may see old or erased words
   //    the three read ports never stall one another
   //    the array is not reset; unwritten words read as unknown in simulation

   // All control state in one record
   typedef struct packed {
      // Command sequencer and erase walk position
      fbep_state_type state;
      logic [BLK_W-1:0] blk;
      logic [BLK_OFS_W-1:0] ofs;
      // Protection settings, one bit per 2 KB unit
      logic [UNIT_CNT-1:0] ronly;
      logic [UNIT_CNT-1:0] xonly;
      // Registered answers, so every output leaves a flip-flop
      fbep_rd_rsp_type fet;
      fbep_rd_rsp_type drd;
      fbep_rd_rsp_type dbg;
      fbep_mod_rsp_type mod;
   } fbep_ctl_type;

   // Current and next copies of the record
   fbep_ctl_type st_r;
   fbep_ctl_type st_nxt;

   // Storage array, not reset: flash content survives reset.
   // Its write port stays outside the state record so it can map onto a RAM.
   logic [31:0] mem [WORDS];
   logic mem_we;
   logic [ADDR_W-1:0] mem_waddr;
   logic [31:0] mem_wdata;

   logic [UNIT_W-1:0] cmd_unit;
   logic cmd_locked;
   logic [UNIT_CNT-1:0] ronly_nxt;
   logic [UNIT_CNT-1:0] xonly_nxt;
   fbep_rd_req_type rd_req [3];
   fbep_rd_rsp_type rd_ans [3];

   // Unit index is the upper address bits: two 1 KB blocks share one unit
   assign cmd_unit = mod_req.addr[ADDR_W-1:UNIT_LSB];
   // Either setting locks the unit against any change of its contents
   assign cmd_locked = st_r.ronly[cmd_unit] | st_r.xonly[cmd_unit];

   // Per-unit setting update; a bit only ever rises, so code cannot be unlocked
   for (genvar u = 0; u < UNIT_CNT; u++) begin : g_unit
      logic hit;
      // Write strobe picks the unit by its index
      assign hit = prot_req.wr & (prot_req.unit == UNIT_W'(u));
      assign ronly_nxt[u] = st_r.ronly[u] | (hit & prot_req.ronly);
      assign xonly_nxt[u] = st_r.xonly[u] | (hit & prot_req.xonly);
   end

   // Read ports gathered so that one loop serves all three masters
   assign rd_req[0] = ifetch_req;
   assign rd_req[1] = dread_req;
   assign rd_req[2] = dbg_req;

   // Read answer for one master; only fetches may see execute-only units
   // Pure function of its inputs, so each read port gets its own copy
   function automatic fbep_rd_rsp_type rd_answer(input fbep_rd_req_type rq,
                                                 input logic is_fetch,
                                                 input logic [UNIT_CNT-1:0] xo,
                                                 input logic [31:0] word);
      fbep_rd_rsp_type r;
      logic [UNIT_W-1:0] u;
      // Unit of the addressed word decides whether a non-fetch read is allowed
      u = rq.addr[ADDR_W-1:UNIT_LSB];
      r.valid = rq.req;
      r.denied = rq.req & xo[u] & ~is_fetch;
      // Denied answers carry zeros, never the stored word
      r.data = (rq.req & ~r.denied) ? word : 32'h0000_0000;
      return r;
   endfunction : rd_answer

   // One answer per master; index 0 is the fetch port, the only one allowed into
   // execute-only units. All three see the array at once, so no master waits.
   for (genvar g = 0; g < 3; g++) begin : g_rd
      assign rd_ans[g] = rd_answer(rd_req[g], 1'(g == 0), st_r.xonly,
                                   mem[rd_req[g].addr]);
   end

   // Next-state logic: protection, erase walk, program and read answers
   always_comb begin
      st_nxt = st_r;
      mem_we = 1'b0;
      mem_waddr = mod_req.addr;
      mem_wdata = mod_req.wdata;

      // Defaults: done and refused are one-cycle pulses
      st_nxt.mod.done = 1'b0;
      st_nxt.mod.refused = 1'b0;

      // Settings act on commands and reads from the next cycle on
      st_nxt.ronly = ronly_nxt;
      st_nxt.xonly = xonly_nxt;

      // Command sequencer; busy stays high for the whole erase walk
      unique case (st_r.state)
         FBEP_IDLE: begin
            if (mod_req.erase | mod_req.prog) begin
               if (cmd_locked) begin
                  // Refused at once: the array is not touched
                  st_nxt.mod.refused = 1'b1;
                  st_nxt.mod.done = 1'b1;
               end else if (mod_req.erase) begin
                  // Erase wins over program when both are raised
                  st_nxt.state = FBEP_ERASE;
                  st_nxt.blk = mod_req.addr[ADDR_W-1:BLK_OFS_W];
                  st_nxt.ofs = '0;
                  st_nxt.mod.busy = 1'b1;
               end else begin
                  // Programming can only clear bits, as real flash does
                  mem_we = 1'b1;
                  mem_wdata = mem[mod_req.addr] & mod_req.wdata;
                  st_nxt.mod.done = 1'b1;
               end
            end
         end
         FBEP_ERASE: begin
            // One word per cycle; commands arriving meanwhile are ignored.
            // A 256-cycle walk was traded for a single narrow write port.
            mem_we = 1'b1;
            mem_waddr = {st_r.blk, st_r.ofs};
            mem_wdata = ERASED_WORD;
            st_nxt.ofs = st_r.ofs + 1'b1;
            // Last word written: done comes together with busy falling
            if (st_r.ofs == BLK_OFS_W'(BLK_WORDS - 1)) begin
               st_nxt.state = FBEP_IDLE;
               st_nxt.mod.busy = 1'b0;
               st_nxt.mod.done = 1'b1;
            end
         end
         // Unused state codes fall back to idle
         default: begin
            st_nxt.state = FBEP_IDLE;
            st_nxt.mod.busy = 1'b0;
         end
      endcase

      // Reads answered the cycle after the request, no wait states
      st_nxt.fet = rd_ans[0];
      st_nxt.drd = rd_ans[1];
      st_nxt.dbg = rd_ans[2];
   end

   // State register with synchronous reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         // Answers, pulses and settings cleared; the array keeps its words
         st_r <= '0;
         st_r.state <= FBEP_IDLE;
         st_r.ronly <= PROT_RESET;
         st_r.xonly <= PROT_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Array write port; only the addressed block is touched
   always_ff @(posedge mclk) begin
      // Held off in reset so a stray enable cannot corrupt stored code
      if (mem_we && !rst) begin
         mem[mem_waddr] <= mem_wdata;
      end
   end

   // Every output is a field of the state register
   assign ifetch_rsp = st_r.fet;
   assign dread_rsp = st_r.drd;
   assign dbg_rsp = st_r.dbg;
   assign mod_rsp = st_r.mod;
   // Settings shown so software can see what is locked
   assign ronly_map = st_r.ronly;
   assign xonly_map = st_r.xonly;
endmodule : fbep_flash
`default_nettype wire

/* fbep_flash_asserts.sv */
// Port assertions for the flash protection block
`timescale 1ns/1ps
`default_nettype none
module fbep_chk
   import fbep_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire fbep_rd_req_type ifetch_req,
   input wire fbep_rd_req_type dread_req,
   input wire fbep_rd_req_type dbg_req,
   input wire fbep_mod_req_type mod_req,
   input wire fbep_rd_rsp_type ifetch_rsp,
   input wire fbep_rd_rsp_type dread_rsp,
   input wire fbep_rd_rsp_type dbg_rsp,
   input wire fbep_mod_rsp_type mod_rsp,
   input wire logic [UNIT_CNT-1:0] ronly_map,
   input wire logic [UNIT_CNT-1:0] xonly_map
);
   logic [UNIT_CNT-1:0] xo;
   logic p;
   // Protection of the unit a command aims at
   assign xo = xonly_map;
   assign p = ronly_map[mod_req.addr[14:9]] | xo[mod_req.addr[14:9]];
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   fetch_fast_a: assert property (ifetch_req.req |=> ifetch_rsp.valid && !ifetch_rsp.denied)
      else $error("fetch answer");
   data_deny_a: assert property (dread_req.req && xo[dread_req.addr[14:9]] |=>
      dread_rsp.denied && dread_rsp.data == 32'h0000_0000) else $error("data deny");
   dbg_deny_a: assert property (dbg_req.req && xo[dbg_req.addr[14:9]] |=>
      dbg_rsp.valid && dbg_rsp.denied) else $error("debug deny");
   data_free_a: assert property (dread_req.req && !xo[dread_req.addr[14:9]] |=>
      dread_rsp.valid && !dread_rsp.denied) else $error("data free");
   ro_refuse_a: assert property (!mod_rsp.busy && (mod_req.prog || mod_req.erase)
      && ronly_map[mod_req.addr[14:9]] |=> mod_rsp.done && mod_rsp.refused) else $error("ro");
   xo_refuse_a: assert property (!mod_rsp.busy && (mod_req.prog || mod_req.erase)
      && xo[mod_req.addr[14:9]] |=> mod_rsp.done && mod_rsp.refused) else $error("xo");
   erase_len_a: assert property (!mod_rsp.busy && mod_req.erase && !p |=>
      mod_rsp.busy ##255 mod_rsp.busy ##1 !mod_rsp.busy && mod_rsp.done) else $error("erase");
   prog_ok_a: assert property (!mod_rsp.busy && mod_req.prog && !mod_req.erase && !p |=>
      mod_rsp.done && !mod_rsp.refused) else $error("program");
endmodule : fbep_chk
bind fbep_flash fbep_chk u_chk (
   .mclk(mclk),
   .rst(rst),
   .ifetch_req(ifetch_req),
   .dread_req(dread_req),
   .dbg_req(dbg_req),
   .mod_req(mod_req),
   .ifetch_rsp(ifetch_rsp),
   .dread_rsp(dread_rsp),
   .dbg_rsp(dbg_rsp),
   .mod_rsp(mod_rsp),
   .ronly_map(ronly_map),
   .xonly_map(xonly_map)
);
`default_nettype wire

/* fbep_master.sv */
// Fetch, data and debug read masters
`timescale 1ns/1ps
`default_nettype none
module fbep_master (
   input wire logic mclk,
   output fbep_pkg::fbep_rd_req_type rq [3],
   input wire fbep_pkg::fbep_rd_rsp_type rs [3]
);
   import fbep_pkg::*;
   // Idle from time zero; answer stands one cycle so it is taken then
   initial rq = '{default: '0};
   task automatic rd(input int n, input logic [ADDR_W-1:0] a, output fbep_rd_rsp_type r);
      @(posedge mclk) rq[n] <= '{1'b1, a};
      @(posedge mclk) rq[n] <= '0;
      #1 r = rs[n];
   endtask : rd
endmodule : fbep_master
`default_nettype wire

/* fbep_pkg.sv */
// Package for the flash block erase and protection logic
package fbep_pkg;
   localparam int FLASH_BYTES = 131072;
   localparam int WORD_BYTES = 4;
   localparam int WORDS = FLASH_BYTES / WORD_BYTES;
   localparam int ADDR_W = 15;
   localparam int BLK_BYTES = 1024;
   localparam int BLK_WORDS = BLK_BYTES / WORD_BYTES;
   localparam int BLK_OFS_W = 8;
   localparam int BLK_CNT = FLASH_BYTES / BLK_BYTES;
   localparam int BLK_W = 7;
   localparam int UNIT_BYTES = 2048;
   localparam int UNIT_CNT = FLASH_BYTES / UNIT_BYTES;
   localparam int UNIT_W = 6;
   localparam int UNIT_LSB = 9;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
   localparam logic [UNIT_CNT-1:0] PROT_RESET = 64'h0000_0000_0000_0000;

   typedef enum logic [1:0] {
      FBEP_IDLE,
      FBEP_ERASE
   } fbep_state_type;

   // Read request from one master
   typedef struct packed {
      logic req;
      logic [ADDR_W-1:0] addr;
   } fbep_rd_req_type;

   // Read answer towards one master
   typedef struct packed {
      logic valid;
      logic denied;
      logic [31:0] data;
   } fbep_rd_rsp_type;

   // Program or erase command
   typedef struct packed {
      logic prog;
      logic erase;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } fbep_mod_req_type;

   // Outcome of a program or erase command
   typedef struct packed {
      logic busy;
      logic done;
      logic refused;
   } fbep_mod_rsp_type;

   // Protection setting loads
   typedef struct packed {
      logic wr;
      logic [UNIT_W-1:0] unit;
      logic ronly;
      logic xonly;
   } fbep_prot_req_type;
endpackage : fbep_pkg

/* tb.sv */
// Self-checking bench for the flash protection block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fbep_pkg::*;
   logic mclk = 0;
   logic rst = 1;
   fbep_rd_req_type rq [3];
   fbep_rd_rsp_type rs [3];
   fbep_mod_req_type mod_req = '0;
   fbep_prot_req_type prot_req = '0;
   fbep_mod_rsp_type mod_rsp;
   logic [UNIT_CNT-1:0] ronly_map;
   logic [UNIT_CNT-1:0] xonly_map;
   fbep_rd_rsp_type r;
   int bad_count = 0;
   int n_checks = 0;
   always #12.5 mclk = ~mclk;
   fbep_master u_mst (.mclk(mclk), .rq(rq), .rs(rs));
   fbep_flash u_dut (.mclk(mclk), .rst(rst), .ifetch_req(rq[0]), .dread_req(rq[1]),
      .dbg_req(rq[2]), .mod_req(mod_req), .prot_req(prot_req), .ifetch_rsp(rs[0]),
      .dread_rsp(rs[1]), .dbg_rsp(rs[2]), .mod_rsp(mod_rsp), .ronly_map(ronly_map),
      .xonly_map(xonly_map));
   task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   // Protection map compare
   task automatic cmp_map(input string n, input logic [UNIT_CNT-1:0] e,
      input logic [UNIT_CNT-1:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_map
   // Read word a on master n; e is {denied, data}
   task automatic rdc(input int n, input logic [14:0] a, input logic [32:0] e);
      u_mst.rd(n, a, r);
      cmp("read", {1'b1, e}, {r.valid, r.denied, r.data});
   endtask : rdc
   // Command pe is {prog, erase}; wait bounded, erase needs 257 cycles
   task automatic cmd(input logic [1:0] pe, input logic [14:0] a, input logic [31:0] d,
      input logic rf);
      int i;
      @(posedge mclk) mod_req <= {pe, a, d};
      @(posedge mclk) mod_req <= '0;
      #1;
      for (i = 0; i < 300 && mod_rsp.done !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      cmp("command", {31'h0000_0000, 1'b0, 1'b1, rf},
         {31'h0000_0000, mod_rsp.busy, mod_rsp.done, mod_rsp.refused});
   endtask : cmd
   task automatic prot(input logic [5:0] u, input logic [1:0] m);
      @(posedge mclk) prot_req <= {1'b1, u, m};
      @(posedge mclk) prot_req <= '0;
   endtask : prot
   // Erase one block beside a programmed one, whole block reads ones;
   // the second erase also raises program, which must lose
   task automatic t_erase;
      cmd(2'b01, 15'h0300, '0, 0);
      cmd(2'b10, 15'h0300, 32'h1234_5678, 0);
      cmd(2'b11, 15'h0200, '0, 0);
      for (int i = 0; i < 256; i++) rdc(1, 15'h0200 + 15'(i), {1'b0, ERASED_WORD});
      rdc(2, 15'h0300, {1'b0, 32'h1234_5678});
   endtask : t_erase
   // Unit 1 read-only covers blocks 2 and 3, block 4 stays free
   task automatic t_ronly;
      prot(6'h01, 2'b10);
      #1;
      cmp_map("read-only map", 64'h0000_0000_0000_0002, ronly_map);
      cmp_map("execute-only map", 64'h0000_0000_0000_0000, xonly_map);
      cmd(2'b10, 15'h0300, 32'h0000_0000, 1);
      cmd(2'b01, 15'h0200, '0, 1);
      rdc(0, 15'h0300, {1'b0, 32'h1234_5678});
      rdc(2, 15'h02FF, {1'b0, ERASED_WORD});
      cmd(2'b01, 15'h0400, '0, 0);
   endtask : t_ronly
   // Unit 2 execute-only: fetch only, no changes
   task automatic t_xonly;
      cmd(2'b10, 15'h0401, 32'h0F0F_0F0F, 0);
      prot(6'h02, 2'b01);
      #1;
      cmp_map("execute-only map", 64'h0000_0000_0000_0004, xonly_map);
      cmp_map("read-only map", 64'h0000_0000_0000_0002, ronly_map);
      rdc(0, 15'h0401, {1'b0, 32'h0F0F_0F0F});
      rdc(1, 15'h0401, {1'b1, 32'h0000_0000});
      rdc(2, 15'h04FF, {1'b1, 32'h0000_0000});
      cmd(2'b01, 15'h0500, '0, 1);
      cmd(2'b10, 15'h0401, 32'h0000_0000, 1);
   endtask : t_xonly
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // Main sequence after 12 reset cycles
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 0;
      t_erase();
      t_ronly();
      t_xonly();
      complete_run();
   end
   // Run needs about 1330 cycles; cut a hang well beyond that
   initial begin
      #200_000;
      bad_count++;
      complete_run();
   end
endmodule : tb
`default_nettype wire
